// ==== include/macsat_map.vh ====
`ifndef MACSAT_MAP_VH
`define MACSAT_MAP_VH

// Register byte offsets, one aligned 32-bit word each.
`define MACSAT_OFS_OP1_MPY 8'h00
`define MACSAT_OFS_OP1_MPYS 8'h04
`define MACSAT_OFS_OP1_MAC 8'h08
`define MACSAT_OFS_OP1_SIGNED_ACCUMULATE_OPERAND 8'h0c
`define MACSAT_OFS_OP1_HIGH 8'h10
`define MACSAT_OFS_OP2_LOW 8'h14
`define MACSAT_OFS_OP2_HIGH 8'h18
`define MACSAT_OFS_RESULT_WORD_0 8'h1c
`define MACSAT_OFS_RESULT_WORD_1 8'h20
`define MACSAT_OFS_RESULT_WORD_2 8'h24
`define MACSAT_OFS_RESULT_WORD_3 8'h28
`define MACSAT_OFS_CTL 8'h2c

// Control register field positions.
`define MACSAT_CTL_CARRY 0
`define MACSAT_CTL_FRAC 2
`define MACSAT_CTL_SAT 3
`define MACSAT_CTL_MODE_LO 4
`define MACSAT_CTL_MODE_HI 5
`define MACSAT_CTL_OP1W 6
`define MACSAT_CTL_OP2W 7
`define MACSAT_CTL_RESET 8'h00

// Operation modes.
`define MACSAT_MODE_MPY 2'b00
`define MACSAT_MODE_MPYS 2'b01
`define MACSAT_MODE_MAC 2'b10
`define MACSAT_MODE_SIGNED_ACCUMULATE_OPERAND 2'b11

// Cycles from the operand-two write to the complete result.
`define MACSAT_LAT_16X16 3'd3
`define MACSAT_LAT_32X16 3'd7
`define MACSAT_LAT_16X32 3'd4
`define MACSAT_LAT_32X32 3'd6

// Saturation limits.
`define MACSAT_POS32 32'h7fffffff
`define MACSAT_NEG32 32'h80000000
`define MACSAT_POS64 64'h7fffffffffffffff
`define MACSAT_NEG64 64'h8000000000000000

// AXI responses.
`define MACSAT_RESP_OKAY 2'b00
`define MACSAT_RESP_SLVERR 2'b10

`endif

// ==== hw/macsat_sat.v ====
`timescale 1ns/10ps
`default_nettype none
`include "macsat_map.vh"

module macsat_sat (
	// Raw result and flags
	input wire [63:0] value,
	input wire carry,
	input wire wide,
	// Adjusted result
	output reg [63:0] sat
);

	always @* begin
		sat = value;
		if (wide) begin
			if (!carry && value[63]) begin
				sat = `MACSAT_POS64;
			end else if (carry && !value[63]) begin
				sat = `MACSAT_NEG64;
			end
		end else begin
			// Only the low two words saturate; the upper words pass.
			if (!carry && value[31]) begin
				sat[31:0] = `MACSAT_POS32;
			end else if (carry && !value[31]) begin
				sat[31:0] = `MACSAT_NEG32;
			end
		end
	end

endmodule // macsat_sat
`default_nettype wire

// ==== hw/macsat_timer.v ====
`timescale 1ns/10ps
`default_nettype none
`include "macsat_map.vh"

module macsat_timer (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Start of an operation and its latency
	input wire load,
	input wire [2:0] load_val,
	// Status
	output wire commit,
	output wire busy,
	output reg ready_pulse
);

	reg [2:0] cnt;

	assign busy = (cnt != 3'd0);
	assign commit = (cnt == 3'd1);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 3'd0;
			ready_pulse <= 1'b0;
		end else begin
			if (load) begin
				cnt <= load_val;
			end else if (busy) begin
				cnt <= cnt - 3'd1;
			end
			// The pulse rises with the commit edge, so every word is valid
			// at the first DMA read and stays valid for the whole sweep.
			ready_pulse <= commit && !load;
		end
	end

endmodule // macsat_timer
`default_nettype wire

// ==== hw/macsat_top.v ====
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "macsat_map.vh"

module macsat_top (
	// Clock and reset
	input wire MCLK,
	input wire RST,
	// AXI4-Lite write address and data
	input wire [31:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output wire S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output wire S_AXI_WREADY,
	// AXI4-Lite write response
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	// AXI4-Lite read
	input wire [31:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output wire S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY,
	// DMA trigger
	output wire DMA_READY
);

	reg aw_full, w_full, start_d, pend_c, shadow_c, ovr_c, next_rok;
	reg op1_32, op2_32, sat_en, frac_en, carry;
	reg [31:0] aw_addr, w_data, op1, op2, next_rdata;
	reg [3:0] w_strb, ovr;
	reg [1:0] mode;
	reg [2:0] start_lat;
	reg [63:0] res, pend, shadow;
	integer i;

	wire commit, busy, wr_go, hi_zero, wen, byte_wr, sgn, wide;
	wire wr_op1, wr_op1hi, wr_op2lo, wr_op2hi, wr_ctl, wr_ok;
	wire [7:0] wa, ctl_rd;
	wire [3:0] wr_res;
	wire [63:0] sat_acc, sat_rd, acc_in, rd_res;
	wire [31:0] a32, b32;
	wire signed [32:0] a_s, b_s;
	wire signed [65:0] prod;
	wire [64:0] sum_w;
	wire [32:0] sum_n;
	wire [15:0] sext_lo, sext_op2, wd16;

	// Write channel: address and data are held apart until both arrived.
	assign S_AXI_AWREADY = !aw_full;
	assign S_AXI_WREADY = !w_full;
	assign wr_go = aw_full && w_full && !S_AXI_BVALID;
	assign hi_zero = (aw_addr[31:8] == 24'h0) && (aw_addr[1:0] == 2'b00);
	assign wa = aw_addr[7:0];
	assign wen = wr_go && hi_zero && (w_strb[1:0] != 2'b00);
	assign byte_wr = w_strb[0] && !w_strb[1];
	assign wr_op1 = wen && (wa[7:4] == 4'h0);
	assign wr_op1hi = wen && (wa == `MACSAT_OFS_OP1_HIGH);
	assign wr_op2lo = wen && (wa == `MACSAT_OFS_OP2_LOW);
	assign wr_op2hi = wen && (wa == `MACSAT_OFS_OP2_HIGH);
	assign wr_ctl = wen && (wa == `MACSAT_OFS_CTL);
	assign wr_res[0] = wen && (wa == `MACSAT_OFS_RESULT_WORD_0);
	assign wr_res[1] = wen && (wa == `MACSAT_OFS_RESULT_WORD_1);
	assign wr_res[2] = wen && (wa == `MACSAT_OFS_RESULT_WORD_2);
	assign wr_res[3] = wen && (wa == `MACSAT_OFS_RESULT_WORD_3);
	assign wr_ok = hi_zero && (wa <= `MACSAT_OFS_CTL);
	assign sext_lo = {{8{aw_addr[2] & w_data[7]}}, w_data[7:0]};
	assign sext_op2 = {{8{mode[0] & w_data[7]}}, w_data[7:0]};
	assign wd16 = w_data[15:0];

	always @(posedge MCLK or posedge RST) begin
		if (RST) begin
			aw_full <= 1'b0;
			aw_addr <= 32'h0;
			w_full <= 1'b0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `MACSAT_RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && !aw_full) begin
				aw_full <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && !w_full) begin
				w_full <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
			if (wr_go) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_ok ? `MACSAT_RESP_OKAY : `MACSAT_RESP_SLVERR;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// Operands and control fields.
	always @(posedge MCLK or posedge RST) begin
		if (RST) begin
			op1 <= 32'h0;
			op2 <= 32'h0;
			mode <= `MACSAT_MODE_MPY;
			op1_32 <= 1'b0;
			op2_32 <= 1'b0;
			sat_en <= 1'b0;
			frac_en <= 1'b0;
		end else begin
			if (wr_op1) begin
				mode <= wa[3:2];
				op1_32 <= 1'b0;
				op1[15:0] <= byte_wr ? sext_lo : wd16;
			end
			if (wr_op1hi) begin
				op1_32 <= 1'b1;
				op1[31:16] <= byte_wr ? {{8{w_data[7]}}, w_data[7:0]} : wd16;
			end
			if (wr_op2lo) begin
				op2_32 <= 1'b0;
				op2[15:0] <= byte_wr ? sext_op2 : wd16;
			end
			if (wr_op2hi) begin
				op2_32 <= 1'b1;
				op2[31:16] <= byte_wr ? {{8{w_data[7]}}, w_data[7:0]} : wd16;
			end
			if (wr_ctl && w_strb[0]) begin
				mode <= w_data[`MACSAT_CTL_MODE_HI:`MACSAT_CTL_MODE_LO];
				op1_32 <= w_data[`MACSAT_CTL_OP1W];
				op2_32 <= w_data[`MACSAT_CTL_OP2W];
				sat_en <= w_data[`MACSAT_CTL_SAT];
				frac_en <= w_data[`MACSAT_CTL_FRAC];
			end
		end
	end

	// Latency depends on which operand-two half starts the operation.
	always @* begin
		if (wr_op2hi) begin
			start_lat = op1_32 ? `MACSAT_LAT_32X32 : `MACSAT_LAT_16X32;
		end else begin
			start_lat = op1_32 ? `MACSAT_LAT_32X16 : `MACSAT_LAT_16X16;
		end
	end

	macsat_timer u_timer (
		.clk(MCLK),
		.rst(RST),
		.load(wr_op2lo || wr_op2hi),
		.load_val(start_lat),
		.commit(commit),
		.busy(busy),
		.ready_pulse(DMA_READY)
	);

	// Arithmetic works on the operands as stored one cycle after the start.
	assign sgn = mode[0];
	assign wide = op1_32 || op2_32;
	assign a32 = op1_32 ? op1 : {{16{sgn & op1[15]}}, op1[15:0]};
	assign b32 = op2_32 ? op2 : {{16{sgn & op2[15]}}, op2[15:0]};
	assign a_s = {sgn & a32[31], a32};
	assign b_s = {sgn & b32[31], b32};
	assign prod = a_s * b_s;

	macsat_sat u_sat_acc (
		.value(res),
		.carry(carry),
		.wide(wide),
		.sat(sat_acc)
	);

	// The prior sum is saturated to the size of the new result first.
	assign acc_in = !mode[1] ? 64'h0 : (sat_en ? sat_acc : res);
	assign sum_w = {sgn & prod[63], prod[63:0]} + {sgn & acc_in[63], acc_in};
	assign sum_n = {sgn & prod[31], prod[31:0]} +
		{sgn & acc_in[31], acc_in[31:0]};

	always @(posedge MCLK or posedge RST) begin
		if (RST) begin
			start_d <= 1'b0;
			pend <= 64'h0;
			pend_c <= 1'b0;
		end else begin
			start_d <= wr_op2lo || wr_op2hi;
			if (start_d) begin
				pend <= wide ? sum_w[63:0] :
					{{32{sgn & sum_n[32]}}, sum_n[31:0]};
				pend_c <= wide ? sum_w[64] : sum_n[32];
			end
		end
	end

	// Result words and carry. A write that arrives while busy, before the commit
	// cycle, is parked and replaces the computed word when the operation ends.
	always @(posedge MCLK or posedge RST) begin
		if (RST) begin
			res <= 64'h0;
			carry <= 1'b0;
			shadow <= 64'h0;
			ovr <= 4'h0;
			shadow_c <= 1'b0;
			ovr_c <= 1'b0;
		end else begin
			if (commit) begin
				for (i = 0; i < 4; i = i + 1) begin
					res[16*i +: 16] <= ovr[i] ? shadow[16*i +: 16] :
						pend[16*i +: 16];
				end
				carry <= ovr_c ? shadow_c : pend_c;
				ovr <= 4'h0;
				ovr_c <= 1'b0;
			end
			for (i = 0; i < 4; i = i + 1) begin
				if (wr_res[i] && busy && !commit) begin
					shadow[16*i +: 16] <= wd16;
					ovr[i] <= 1'b1;
				end else if (wr_res[i]) begin
					res[16*i +: 16] <= wd16;
				end
			end
			if (wr_ctl && w_strb[0] && busy && !commit) begin
				shadow_c <= w_data[`MACSAT_CTL_CARRY];
				ovr_c <= 1'b1;
			end else if (wr_ctl && w_strb[0]) begin
				carry <= w_data[`MACSAT_CTL_CARRY];
			end
		end
	end

	macsat_sat u_sat_rd (
		.value(res),
		.carry(carry),
		.wide(wide),
		.sat(sat_rd)
	);

	// Stored words stay raw; saturation is applied on the way out and to the
	// accumulate input, so clearing the enable reads the raw value for a context save.
	assign rd_res = sat_en ? sat_rd : res;
	assign ctl_rd = {op2_32, op1_32, mode, sat_en, frac_en, 1'b0, carry};

	always @* begin
		next_rdata = 32'h0;
		next_rok = (S_AXI_ARADDR[31:8] == 24'h0) &&
			(S_AXI_ARADDR[1:0] == 2'b00);
		// Until the commit edge the old words are returned.
		case (S_AXI_ARADDR[7:0])
		`MACSAT_OFS_OP1_MPY,
		`MACSAT_OFS_OP1_MPYS,
		`MACSAT_OFS_OP1_MAC,
		`MACSAT_OFS_OP1_SIGNED_ACCUMULATE_OPERAND: begin
			next_rdata[15:0] = op1[15:0];
		end
		`MACSAT_OFS_OP1_HIGH: begin
			next_rdata[15:0] = op1[31:16];
		end
		`MACSAT_OFS_OP2_LOW: begin
			next_rdata[15:0] = op2[15:0];
		end
		`MACSAT_OFS_OP2_HIGH: begin
			next_rdata[15:0] = op2[31:16];
		end
		`MACSAT_OFS_RESULT_WORD_0: begin
			next_rdata[15:0] = rd_res[15:0];
		end
		`MACSAT_OFS_RESULT_WORD_1: begin
			next_rdata[15:0] = rd_res[31:16];
		end
		`MACSAT_OFS_RESULT_WORD_2: begin
			next_rdata[15:0] = rd_res[47:32];
		end
		`MACSAT_OFS_RESULT_WORD_3: begin
			next_rdata[15:0] = rd_res[63:48];
		end
		`MACSAT_OFS_CTL: begin
			next_rdata[7:0] = ctl_rd;
		end
		default: begin
			next_rok = 1'b0;
		end
		endcase
		if (!next_rok) begin
			next_rdata = 32'h0;
		end
	end

	assign S_AXI_ARREADY = !S_AXI_RVALID;

	always @(posedge MCLK or posedge RST) begin
		if (RST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0;
			S_AXI_RRESP <= `MACSAT_RESP_OKAY;
		end else begin
			if (S_AXI_ARVALID && !S_AXI_RVALID) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= next_rdata;
				S_AXI_RRESP <= next_rok ? `MACSAT_RESP_OKAY : `MACSAT_RESP_SLVERR;
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

endmodule // macsat_top
`default_nettype wire

// ==== tb/macsat_props.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "macsat_map.vh"
module macsat_props (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST,
	// Bus
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_RVALID,
	// Trigger
	input wire logic DMA_READY
);
	logic [7:0] aw_q;
	logic [1:0] ws_q;
	logic bv_q;
	logic w32;
	wire done = S_AXI_BVALID && !bv_q;
	wire aw = S_AXI_AWVALID && S_AXI_AWREADY;
	wire ar = S_AXI_ARVALID && S_AXI_ARREADY;
	always @(posedge MCLK or posedge RST) begin
		if (RST) begin
			aw_q <= 8'h00;
			ws_q <= 2'h0;
			bv_q <= 1'b0;
			w32 <= 1'b0;
		end else begin
			bv_q <= S_AXI_BVALID;
			if (aw)
				aw_q <= S_AXI_AWADDR[7:0];
			if (S_AXI_WVALID && S_AXI_WREADY)
				ws_q <= S_AXI_WSTRB[1:0];
			// Control writes also change the width of operand one; only operand-one writes are tracked here.
			if (done && aw_q <= 8'h10)
				w32 <= (aw_q == 8'h10);
		end
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	a_aw_held: assert property (aw |=> !S_AXI_AWREADY)
		else $error("address taken while one is held");
	a_b_after: assert property (aw && S_AXI_WVALID && S_AXI_WREADY
		&& !S_AXI_BVALID |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
		else $error("write response late or early");
	a_r_after: assert property (ar |=> S_AXI_RVALID)
		else $error("read data late");
	a_ar_refused: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read address taken during data");
	a_unmapped_rd: assert property (ar && S_AXI_ARADDR[31:8] != 24'h0
		|=> S_AXI_RDATA == 32'h0 && S_AXI_RRESP == `MACSAT_RESP_SLVERR)
		else $error("unmapped read answered");
	a_ctl_read: assert property (ar && S_AXI_ARADDR == 32'h2c
		|=> S_AXI_RDATA[31:8] == 24'h0 && !S_AXI_RDATA[1])
		else $error("control reserved bits set");
	a_dma_pulse: assert property (DMA_READY |=> !DMA_READY)
		else $error("trigger longer than one cycle");
	a_byte_start: assert property (done && aw_q == 8'h14
		&& ws_q == 2'b01 && !w32 |-> !DMA_READY[*3] ##1 DMA_READY)
		else $error("short product trigger not at three");
	c_dma: cover property (DMA_READY);
	c_bad: cover property (S_AXI_RVALID && S_AXI_RRESP != 2'b00);
	c_byte: cover property (done && aw_q == 8'h14 && ws_q == 2'b01);
endmodule // macsat_props
bind macsat_top macsat_props u_props (
	.MCLK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
	.S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID,
	.S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
	.S_AXI_RRESP, .S_AXI_RVALID, .DMA_READY
);
`default_nettype wire

// ==== tb/macsat_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module macsat_host (
	// Clock
	input wire logic MCLK,
	// Write channels
	output logic [31:0] S_AXI_AWADDR = 32'h0,
	output logic S_AXI_AWVALID = 1'b0,
	input wire logic S_AXI_AWREADY,
	output logic [31:0] S_AXI_WDATA = 32'h0,
	output logic [3:0] S_AXI_WSTRB = 4'h0,
	output logic S_AXI_WVALID = 1'b0,
	input wire logic S_AXI_WREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	output logic S_AXI_BREADY = 1'b1,
	// Read channels
	output logic [31:0] S_AXI_ARADDR = 32'h0,
	output logic S_AXI_ARVALID = 1'b0,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_RVALID,
	output logic S_AXI_RREADY = 1'b1,
	// Trigger
	input wire logic DMA_READY
);
	// Ready lines stay high, so no answer ever waits on this master.
	int n_dma = 0;
	int dma_len = 4;
	logic [31:0] dw [4];
	task automatic wr(input logic [31:0] a, d, input logic [3:0] s,
		output logic [1:0] r);
		logic aw_on;
		logic w_on;
		// Each channel is released once, at its own handshake edge, so a
		// following call never meets a second assignment in one step.
		aw_on = 1'b1;
		w_on = 1'b1;
		S_AXI_AWADDR <= a;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WDATA <= d;
		S_AXI_WSTRB <= s;
		S_AXI_WVALID <= 1'b1;
		do begin
			@(posedge MCLK);
			if (aw_on && S_AXI_AWREADY) begin
				S_AXI_AWVALID <= 1'b0;
				aw_on = 1'b0;
			end
			if (w_on && S_AXI_WREADY) begin
				S_AXI_WVALID <= 1'b0;
				w_on = 1'b0;
			end
		end while (!S_AXI_BVALID);
		r = S_AXI_BRESP;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		do @(posedge MCLK); while (!S_AXI_ARREADY);
		S_AXI_ARVALID <= 1'b0;
		do @(posedge MCLK); while (!S_AXI_RVALID);
		d = S_AXI_RDATA;
		r = S_AXI_RRESP;
	endtask
	always @(posedge MCLK) begin
		if (DMA_READY) begin
			logic [1:0] r;
			for (int i = 0; i < dma_len; i++)
				rd(32'h1c + 32'(4 * i), dw[i], r);
			n_dma++;
		end
	end
endmodule // macsat_host
`default_nettype wire

// ==== tb/macsat_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "macsat_map.vh"
module macsat_top_tb;
	logic MCLK = 1'b0;
	logic RST = 1'b1;
	logic [31:0] S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
	logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
	logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
	logic S_AXI_RVALID, S_AXI_RREADY, DMA_READY;
	logic [31:0] d;
	int n_fail = 0;
	int checks_done = 0;
	int k;
	macsat_top DUT (.MCLK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID,
		.S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
		.S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
		.S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
		.S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .DMA_READY);
	macsat_host P (.MCLK, .S_AXI_AWADDR, .S_AXI_AWVALID,
		.S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
		.S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
		.S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
		.S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .DMA_READY);
	initial forever #2.5 MCLK = ~MCLK;
	task automatic chk(input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic W(input logic [31:0] a, v, input logic [3:0] s);
		P.wr(a, v, s, r);
	endtask
	task automatic R(input logic [31:0] a, exp);
		P.rd(a, d, r);
		chk(d, exp);
	endtask
	// The bench reads only after the trigger's reads end: one read channel.
	task automatic op(input logic [31:0] a, v, input logic [3:0] s);
		k = P.n_dma;
		W(a, v, s);
		wait (P.n_dma != k);
	endtask
	initial begin
		#50000;
		n_fail++;
		conclude;
	end
	initial begin
		repeat (20) @(posedge MCLK);
		RST <= 1'b0;
		@(posedge MCLK);
		R(`MACSAT_OFS_CTL, 32'h0);
		W(`MACSAT_OFS_CTL, 32'hff, 4'hf);
		R(`MACSAT_OFS_CTL, 32'hfd);
		for (int m = 0; m < 4; m++) begin
			W(`MACSAT_OFS_CTL, 32'h0, 4'hf);
			W(`MACSAT_OFS_RESULT_WORD_0, 32'h0, 4'hf);
			W(`MACSAT_OFS_RESULT_WORD_1, 32'h0, 4'hf);
			W(32'(12 - 4 * m), 32'hfffe, 4'hf);
			W(32'(4 * m), 32'hfffe, 4'hf);
			op(`MACSAT_OFS_OP2_LOW, 32'h3, 4'hf);
			chk(P.dw[0], 32'hfffa);
			chk(P.dw[1], (m % 2) ? 32'hffff : 32'h2);
			P.rd(`MACSAT_OFS_CTL, d, r);
			chk(d & 32'h30, 32'(16 * m));
		end
		W(`MACSAT_OFS_CTL, 32'h8, 4'hf);
		W(`MACSAT_OFS_RESULT_WORD_0, 32'hfa60, 4'hf);
		W(`MACSAT_OFS_RESULT_WORD_1, 32'h7fff, 4'hf);
		W(`MACSAT_OFS_OP1_SIGNED_ACCUMULATE_OPERAND, 32'h50, 4'h1);
		op(`MACSAT_OFS_OP2_LOW, 32'h12, 4'h1);
		chk(P.dw[0], 32'hffff);
		chk(P.dw[1], 32'h7fff);
		chk(P.dw[3], 32'h0);
		W(`MACSAT_OFS_RESULT_WORD_0, 32'h0, 4'hf);
		W(`MACSAT_OFS_RESULT_WORD_1, 32'h0, 4'hf);
		W(`MACSAT_OFS_CTL, 32'h9, 4'hf);
		W(`MACSAT_OFS_OP1_SIGNED_ACCUMULATE_OPERAND, 32'h82, 4'h1);
		op(`MACSAT_OFS_OP2_LOW, 32'h4f, 4'h1);
		chk(P.dw[0], 32'h0);
		chk(P.dw[1], 32'h8000);
		P.dma_len = 1;
		W(`MACSAT_OFS_CTL, 32'h0, 4'hf);
		k = P.n_dma;
		W(`MACSAT_OFS_OP1_HIGH, 32'h1, 4'hf);
		W(`MACSAT_OFS_OP2_LOW, 32'h2, 4'hf);
		W(`MACSAT_OFS_RESULT_WORD_0, 32'h1111, 4'hf);
		W(`MACSAT_OFS_RESULT_WORD_1, 32'h2222, 4'hf);
		wait (P.n_dma != k);
		chk(P.dw[0], 32'h1111);
		R(`MACSAT_OFS_RESULT_WORD_1, 32'h2222);
		// A wide operand two restarts the running 32x16 product.
		P.dma_len = 4;
		W(`MACSAT_OFS_OP1_MPY, 32'h2, 4'hf);
		W(`MACSAT_OFS_OP1_HIGH, 32'h1, 4'hf);
		W(`MACSAT_OFS_OP2_LOW, 32'h3, 4'hf);
		op(`MACSAT_OFS_OP2_HIGH, 32'h1, 4'hf);
		chk(P.dw[0], 32'h6);
		chk(P.dw[1], 32'h5);
		chk(P.dw[2], 32'h1);
		chk(P.dw[3], 32'h0);
		R(`MACSAT_OFS_CTL, 32'hc0);
		P.rd(32'h100, d, r);
		chk(d, 32'h0);
		chk({30'h0, r}, {30'h0, `MACSAT_RESP_SLVERR});
		P.wr(32'h30, 32'h5, 4'hf, r);
		chk({30'h0, r}, {30'h0, `MACSAT_RESP_SLVERR});
		conclude;
	end
endmodule // macsat_top_tb
`default_nettype wire
